// file: logic/plir_regs.vh
// Constants for the PHY side of the link interface reset and restart handshake
`ifndef PLIR_REGS_VH
`define PLIR_REGS_VH

// Core clock period
`define PLIR_CLK_NS              10
// Link power pulse phases, kept for reference by the far side
`define PLIR_PULSE_LOW_TIME_MIN_NS  90
`define PLIR_PULSE_LOW_TIME_MAX_NS  1000
`define PLIR_PULSE_HIGH_TIME_MIN_NS 90
`define PLIR_PULSE_HIGH_TIME_MAX_NS 1000
// Absence window, least value rounded up to whole cycles
`define PLIR_POWER_ABSENCE_DETECT_TIME_NS 1200
`define PLIR_ABSENCE_CYC \
  ((`PLIR_POWER_ABSENCE_DETECT_TIME_NS + `PLIR_CLK_NS - 1) / `PLIR_CLK_NS)
// Wait the link keeps after the interface clock stops
`define PLIR_POWER_REASSERT_WAIT_TIME_NS 10000
// Interface clock half period in core cycles
`define PLIR_SCLK_HALF           4
// Restart sequence
`define PLIR_INIT_LEN            7
`define PLIR_DIFF_ZERO_CYC       3
// Control and data codes
`define PLIR_CTL_IDLE            2'h0
`define PLIR_CTL_RECEIVE         2'h2
`define PLIR_D_PREFIX            8'hFF
`define PLIR_D_ZERO              8'h00

`endif

// file: logic/plir_lps_mon.v
// Link power status monitor: synchroniser, activity detect, absence timer
`timescale 1ns/10ps
`default_nettype none
`include "plir_regs.vh"

module plir_lps_mon (
  input  wire clk,
  input  wire rst_n,
  input  wire clk_en,
  input  wire lps,
  input  wire diff_mode,
  output reg  lps_present
);

  reg       lps_s1;
  reg       lps_s2;
  reg       lps_s3;
  reg [7:0] idle_cnt;
  wire      active;

  localparam integer ABSENCE_LAST_I = `PLIR_ABSENCE_CYC - 1;
  localparam [7:0]   ABSENCE_LAST   = ABSENCE_LAST_I[7:0];

  // Pulsed power status counts by edges, a direct one by level
  assign active = diff_mode ? (lps_s2 ^ lps_s3) : lps_s2;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lps_s1      <= 1'b0;
      lps_s2      <= 1'b0;
      lps_s3      <= 1'b0;
      idle_cnt    <= 8'h00;
      lps_present <= 1'b0;
    end else if (clk_en) begin
      lps_s1 <= lps;
      lps_s2 <= lps_s1;
      lps_s3 <= lps_s2;
      if (active) begin
        idle_cnt    <= 8'h00;
        lps_present <= 1'b1;
      end else if (idle_cnt == ABSENCE_LAST) begin
        lps_present <= 1'b0;
      end else begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// file: logic/plir_core.v
// PHY side of the link interface: disable on power loss, clock restart, reset handshake
//
// Contract
// - PHY declares power absent after 1.2 to 2.75 us without activity.
// - Disabled PHY drives Ctl, D, SClk low differentiated, floats them otherwise.
// - Interface reset cancels pending bus and register read requests.
// - Started arbitration is withdrawn or closed with a null packet.
// - Reset during link transmit ends the packet as if Idle.
// - Status made while disabled is discarded, never sent later.
// - PHY restarts SClk promptly once power status returns.
// - Differentiated: Ctl and D zero in exactly one of seven cycles.
// - Undifferentiated: Ctl and D held zero for first seven cycles.
// - From cycle eight only Idle until Receive with prefix shown.
// - Prefix shown for one cycle, then Idle.
// - No packet fragments or partial status after restart.
// - Idle arbitration at cycle seven gives Receive with prefix at eight.
// - Direct strap high means undifferentiated, low differentiated.
// - PHY supplies SClk; interface needs it stable to operate.
`timescale 1ns/10ps
`default_nettype none
`include "plir_regs.vh"

module plir_core (
  input  wire       core_clk,
  input  wire       nrst,
  input  wire       clk_en,
  input  wire       lps,
  input  wire       direct,
  input  wire       arb_idle,
  input  wire       link_tx_active,
  input  wire [1:0] core_ctl,
  input  wire [7:0] core_d,
  input  wire       core_oe,
  output reg        sclk_out,
  output reg        sclk_oe,
  output reg  [1:0] ctl_out,
  output reg        ctl_oe,
  output reg  [7:0] d_out,
  output reg        d_oe,
  output reg        iface_up,
  output reg        reset_done,
  output reg        cancel_req,
  output reg        tx_force_idle,
  output wire       status_discard
);

  localparam [2:0] ST_OFF  = 3'b001;
  localparam [2:0] ST_INIT = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  localparam integer SCLK_LAST_I = `PLIR_SCLK_HALF - 1;
  localparam integer ZERO_CYC_I  = `PLIR_DIFF_ZERO_CYC - 1;
  localparam integer INIT_LAST_I = `PLIR_INIT_LEN - 1;
  localparam [2:0]   SCLK_LAST   = SCLK_LAST_I[2:0];
  localparam [3:0]   ZERO_CYC    = ZERO_CYC_I[3:0];
  localparam [3:0]   INIT_LAST   = INIT_LAST_I[3:0];

  // Divider terminal count, shared by the clock toggle and the edge detect
  function div_wrap;
    input [2:0] cnt;
    begin
      div_wrap = (cnt == SCLK_LAST);
    end
  endfunction

  reg       rst_s1;
  reg       rst_n;
  reg       dir_s1;
  reg       dir_s2;
  reg [2:0] state;
  reg [2:0] div_cnt;
  reg [3:0] cyc;
  reg       diff_mode;
  wire      lps_present;
  wire      sclk_rise;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release and strap synchroniser

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_s1 <= 1'b0;
      dir_s2 <= 1'b0;
    end else if (clk_en) begin
      dir_s1 <= direct;
      dir_s2 <= dir_s1;
    end
  end

  plir_lps_mon u_lps_mon (
    .clk         (core_clk),
    .rst_n       (rst_n),
    .clk_en      (clk_en),
    .lps         (lps),
    .diff_mode   (diff_mode),
    .lps_present (lps_present)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Interface clock and handshake sequencing

  assign sclk_rise = (state != ST_OFF) && !sclk_out &&
                     div_wrap(div_cnt);
  // Status generated before completion never leaves the PHY
  assign status_discard = !reset_done;

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= ST_OFF;
      div_cnt       <= 3'h0;
      cyc           <= 4'h0;
      diff_mode     <= 1'b1;
      sclk_out      <= 1'b0;
      sclk_oe       <= 1'b0;
      ctl_out       <= `PLIR_CTL_IDLE;
      ctl_oe        <= 1'b0;
      d_out         <= `PLIR_D_ZERO;
      d_oe          <= 1'b0;
      iface_up      <= 1'b0;
      reset_done    <= 1'b0;
      cancel_req    <= 1'b0;
      tx_force_idle <= 1'b0;
    end else if (clk_en) begin
      cancel_req    <= 1'b0;
      tx_force_idle <= 1'b0;
      case (state)
        ST_OFF: begin
          diff_mode <= !dir_s2;
          sclk_out  <= 1'b0;
          sclk_oe   <= !dir_s2;
          ctl_out   <= `PLIR_CTL_IDLE;
          d_out     <= `PLIR_D_ZERO;
          ctl_oe    <= !dir_s2;
          d_oe      <= !dir_s2;
          iface_up  <= 1'b0;
          div_cnt   <= 3'h0;
          cyc       <= 4'h0;
          if (lps_present) begin
            state   <= ST_INIT;
            sclk_oe <= 1'b1;
          end
        end
        ST_INIT, ST_RUN: begin
          if (!lps_present) begin
            state         <= ST_OFF;
            reset_done    <= 1'b0;
            iface_up      <= 1'b0;
            sclk_out      <= 1'b0;
            sclk_oe       <= diff_mode;
            ctl_out       <= `PLIR_CTL_IDLE;
            d_out         <= `PLIR_D_ZERO;
            ctl_oe        <= diff_mode;
            d_oe          <= diff_mode;
            cancel_req    <= 1'b1;
            tx_force_idle <= link_tx_active;
          end else begin
            div_cnt <= div_wrap(div_cnt) ? 3'h0 : div_cnt + 3'h1;
            if (div_wrap(div_cnt))
              sclk_out <= !sclk_out;
            if (sclk_rise) begin
              if (state == ST_INIT) begin
                cyc     <= cyc + 4'h1;
                ctl_out <= `PLIR_CTL_IDLE;
                d_out   <= `PLIR_D_ZERO;
                if (diff_mode) begin
                  ctl_oe <= (cyc == ZERO_CYC);
                  d_oe   <= (cyc == ZERO_CYC);
                end else begin
                  ctl_oe <= 1'b1;
                  d_oe   <= 1'b1;
                end
                if (cyc == INIT_LAST)
                  state <= ST_RUN;
              end else if (!reset_done) begin
                ctl_oe <= 1'b1;
                d_oe   <= 1'b1;
                if (ctl_out == `PLIR_CTL_RECEIVE) begin
                  // Prefix shown once; arbitration was idle, so return to Idle
                  ctl_out    <= `PLIR_CTL_IDLE;
                  d_out      <= `PLIR_D_ZERO;
                  reset_done <= 1'b1;
                  iface_up   <= 1'b1;
                end else if (arb_idle) begin
                  ctl_out <= `PLIR_CTL_RECEIVE;
                  d_out   <= `PLIR_D_PREFIX;
                end else begin
                  ctl_out <= `PLIR_CTL_IDLE;
                  d_out   <= `PLIR_D_ZERO;
                end
              end else begin
                ctl_out <= core_ctl;
                d_out   <= core_d;
                ctl_oe  <= core_oe;
                d_oe    <= core_oe;
              end
            end
          end
        end
        default: state <= ST_OFF;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: verif/plir_core_chk.sv
// Port checker for the interface reset and restart block
`timescale 1ns/10ps
`default_nettype none
`include "plir_regs.vh"
module plir_core_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       lps,
  input wire logic       direct,
  input wire logic       sclk_out,
  input wire logic       sclk_oe,
  input wire logic [1:0] ctl_out,
  input wire logic       ctl_oe,
  input wire logic [7:0] d_out,
  input wire logic       d_oe,
  input wire logic       iface_up,
  input wire logic       reset_done,
  input wire logic       cancel_req,
  input wire logic       tx_force_idle,
  input wire logic       status_discard
);
  logic [9:0] low_cnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // Cycles the power status line has stayed low
  always @(posedge core_clk or negedge nrst)
    if (!nrst) low_cnt <= 10'h000;
    else if (lps) low_cnt <= 10'h000;
    else if (low_cnt != 10'h3FF) low_cnt <= low_cnt + 10'h001;
  disc_level_a: assert property (status_discard == !reset_done)
    else $error("discard level wrong");
  done_up_a: assert property (reset_done == iface_up) else $error("done and up differ");
  force_idle_a: assert property (tx_force_idle |-> cancel_req) else $error("lone force");
  cancel_pulse_a: assert property (cancel_req |=> !cancel_req) else $error("long cancel");
  absent_off_a: assert property (low_cnt >= 10'h113 |-> !iface_up)
    else $error("still up without power");
  absent_early_a: assert property ($past(iface_up) && low_cnt < 10'h078 |-> iface_up)
    else $error("dropped too soon");
  early_ctl_a: assert property (!reset_done && ctl_oe && ctl_out != `PLIR_CTL_IDLE
    |-> ctl_out == `PLIR_CTL_RECEIVE && d_out == `PLIR_D_PREFIX) else $error("early state");
  off_diff_a: assert property (low_cnt >= 10'h12C && !direct |-> sclk_oe && !sclk_out
    && ctl_oe && d_oe && ctl_out == 2'h0 && d_out == 8'h00) else $error("off not zero");
  off_undiff_a: assert property (low_cnt >= 10'h12C && direct
    |-> !sclk_oe && !ctl_oe && !d_oe) else $error("off not floating");
  stand_a: assert property (iface_up && $past(iface_up)
    && ($changed(ctl_out) || $changed(d_out)) |-> $rose(sclk_out)) else $error("off edge");
  cover property ($rose(reset_done));
  cover property (tx_force_idle);
  cover property (cancel_req && direct);
endmodule
bind plir_core plir_core_chk u_chk (.core_clk(core_clk), .nrst(nrst), .lps(lps),
  .direct(direct), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ctl_out(ctl_out),
  .ctl_oe(ctl_oe), .d_out(d_out), .d_oe(d_oe), .iface_up(iface_up), .reset_done(reset_done),
  .cancel_req(cancel_req), .tx_force_idle(tx_force_idle), .status_discard(status_discard));
`default_nettype wire

// file: verif/plir_link_model.sv
// Link side model: drives the power status line in either interface mode
`timescale 1ns/10ps
`default_nettype none
`include "plir_regs.vh"
module plir_link_model #(
  parameter PHASE_NS = 160,
  parameter WAIT_NS  = 10000
) (
  input  wire logic       active,
  input  wire logic       diff,
  input  wire logic       sclk,
  input  wire logic [1:0] ctl,
  input  wire logic [7:0] d,
  output var  logic       lps,
  output var  logic       bus_oe,
  output var  logic       lreq_oe,
  output var  logic       seen_done
);
  int n = 0;
  initial begin
    lps = 1'b0;
    {bus_oe, lreq_oe, seen_done} = 3'b000;
  end
  // Link drive changes mid SClk cycle, away from the edge that launches the PHY outputs
  always @(negedge sclk or negedge active) begin
    if (!active) begin
      n         <= 0;
      seen_done <= 1'b0;
      bus_oe    <= 1'b0; // Ctl and D floated once power is dropped
      lreq_oe   <= diff; // LReq low when isolated, floated otherwise
    end else begin
      if (n < 7)
        n <= n + 1;
      bus_oe  <= (n == 1); // Zero on Ctl and D in one early cycle only
      lreq_oe <= diff ? (n == 1) : (n >= 1); // No request before completion
      if (n >= 2 && ctl == `PLIR_CTL_RECEIVE && d == `PLIR_D_PREFIX)
        seen_done <= 1'b1;
    end
  end
  always begin
    wait (active);
    #(diff ? WAIT_NS + 3 : 3);   // Quiet time after the clock stops when isolated, off the core edges
    while (active) begin
      lps = 1'b1;
      #(PHASE_NS);               // Pulse phases within limits when isolated
      if (diff) lps = 1'b0;      // Steady level on a direct connection
      if (diff) #(PHASE_NS);
    end
    lps = 1'b0;                  // Power removed
  end
endmodule
`default_nettype wire

// file: verif/plir_core_tb.sv
// Self-checking bench for the interface reset and restart block
`timescale 1ns/10ps
`default_nettype none
`include "plir_regs.vh"
module plir_core_tb;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        direct   = 1'b0;
  logic        arb_idle = 1'b0;
  logic        tx       = 1'b0;
  logic        core_oe  = 1'b0;
  logic        active   = 1'b0;
  logic [1:0]  core_ctl = 2'h0;
  logic [7:0]  core_d   = 8'h00;
  logic [16:0] rnd      = 17'h17772;
  logic        prv      = 1'b0;
  logic        rise, lps, sclk_out, sclk_oe, ctl_oe, d_oe, iface_up, reset_done, cancel_req;
  logic        tfi, disc;
  logic        l_oe, lr_oe, seen;
  logic [1:0]  ctl_out;
  logic [7:0]  d_out;
  int          fail_count = 0;
  int          tests_run  = 0;
  int          cyc        = 0;
  always #5 core_clk = ~core_clk;
  plir_link_model u_link (.active(active), .diff(!direct), .sclk(sclk_out), .ctl(ctl_out),
    .d(d_out), .lps(lps), .bus_oe(l_oe), .lreq_oe(lr_oe), .seen_done(seen));
  plir_core u_dut (.core_clk(core_clk), .nrst(nrst), .clk_en(1'b1), .lps(lps), .direct(direct),
    .arb_idle(arb_idle), .link_tx_active(tx), .core_ctl(core_ctl), .core_d(core_d),
    .core_oe(core_oe), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ctl_out(ctl_out),
    .ctl_oe(ctl_oe), .d_out(d_out), .d_oe(d_oe), .iface_up(iface_up), .reset_done(reset_done),
    .cancel_req(cancel_req), .tx_force_idle(tfi), .status_discard(disc));
  function logic [16:0] nxt(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  function int exp_rx(input int w);
    return (w == 0) ? 8 : 7 + w;
  endfunction
  task complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      $display("BAD %0t %s saw %h want %h", $time, what, seen, exp);
      fail_count++;
    end
  endtask
  task step;
    @(negedge core_clk);
    rise = sclk_out & ~prv;
    prv = sclk_out;
  endtask
  task run_one(input logic dm, input logic t, input int w);
    int n, oe, rx, i, lp, r1, cn, tf, cf;
    logic up0;
    {n, oe, rx, i, lp, r1, cn, tf, cf} = '0;
    up0 = iface_up;
    direct = dm;
    tx = t;
    active = 1'b0;
    arb_idle = 1'b0;
    repeat (400) begin
      step();
      cn += cancel_req;
      tf += tfi;
    end
    check(8'(cn), {7'h00, up0}, "cancel count");
    check(8'(tf), {7'h00, up0 & t}, "forced idle");
    check({7'h00, disc}, 8'h01, "discard off");
    active = 1'b1;
    while (i < 3000 && !(rx != 0 && n > rx)) begin
      step();
      i++;
      if (lps && lp == 0) lp = i;
      cf += l_oe & ctl_oe & ((ctl_out != 2'h0) | (d_out != 8'h00));
      if (rise) n++;
      if (rise && n == 1) r1 = i;
      if (rise && n <= 7) oe += ctl_oe & d_oe & (ctl_out == 2'h0) & (d_out == 8'h00);
      if (rise && n == 6 + w) arb_idle = 1'b1;
      if (rise && rx == 0 && ctl_out == `PLIR_CTL_RECEIVE && d_out == `PLIR_D_PREFIX) rx = n;
    end
    check(8'(r1 - lp <= 20), 8'h01, "slow restart");
    check(8'(oe), dm ? 8'h07 : 8'h01, "zero drive cycles");
    check(8'(rx), 8'(exp_rx(w)), "completion cycle");
    check({6'h00, ctl_out}, {6'h00, `PLIR_CTL_IDLE}, "idle after prefix");
    check({6'h00, reset_done, disc}, 8'h02, "done flags");
    check(8'(cf), 8'h00, "drive clash");
    check({7'h00, seen}, 8'h01, "link saw completion");
    check({7'h00, lr_oe}, {7'h00, dm}, "lreq hold");
    repeat (3) begin
      rnd = nxt(rnd);
      {core_oe, core_d, core_ctl} = rnd[10:0];
      rise = 1'b0;
      while (!rise) step();
      check({6'h00, ctl_oe, d_oe}, {6'h00, core_oe, core_oe}, "oe pass");
      check({6'h00, ctl_out}, {6'h00, core_ctl}, "ctl pass");
      check(d_out, core_d, "d pass");
    end
  endtask
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  initial begin
    repeat (6) @(negedge core_clk);
    nrst = 1'b1;
    for (int j = 0; j < 6; j++) begin
      rnd = nxt(rnd);
      if (j < 4) run_one(j[0], j[0] ^ j[1], (j * 5) % 7);
      else run_one(rnd[0], rnd[1], int'(rnd[3:2]));
      $display("test %0d done", j);
    end
    complete_run();
  end
endmodule
`default_nettype wire
